// [sbs_regs.svh]
// Constants shared by both ends of the burst SRAM link.
`ifndef SBS_REGS_SVH
`define SBS_REGS_SVH
`define SBS_ADDR_W   8
`define SBS_LANES    4
`define SBS_LANE_W   8
`define SBS_CNT_W    2
`define SBS_RD_LAT   2
`endif

// [sbs_pkg.sv]
// Types shared by both ends of the burst SRAM link.
package sbs_pkg;
   // Cycle kinds; the device decodes all but SBS_IDLE each edge.
   typedef enum logic [2:0] {
      SBS_DESEL  = 3'h0,
      SBS_BEGIN  = 3'h1,
      SBS_NEXT   = 3'h3,
      SBS_HOLD   = 3'h2,
      SBS_IDLE   = 3'h6
   } sbs_cyc_e;
endpackage

// [sbs_if.sv]
// Pin bundle between the burst SRAM and its controller.
`timescale 1ns/1ns
`include "sbs_regs.svh"
interface sbs_if;
   logic                                 chip_select_primary_n;
   logic                                 chip_select_high;
   logic                                 chip_select_second_n;
   logic                                 cpu_load_strobe_n;
   logic                                 cache_load_strobe_n;
   logic                                 burst_step_n;
   logic                                 global_store_n;
   logic                                 byte_store_enable_n;
   logic [`SBS_LANES-1:0]                lane_store_n;
   logic                                 burst_order_select;
   logic                                 out_enable_n;
   logic [`SBS_ADDR_W-1:0]               addr;
   logic [`SBS_LANES*`SBS_LANE_W-1:0]    dq_ctl_out;
   logic                                 dq_ctl_oe;
   logic [`SBS_LANES*`SBS_LANE_W-1:0]    dq_mem_out;
   logic                                 dq_mem_oe;
   logic [`SBS_LANES*`SBS_LANE_W-1:0]    dq;
   // Wire level resolved from the two enables.
   assign dq = dq_mem_oe ? dq_mem_out :
               dq_ctl_oe ? dq_ctl_out : '0;
   modport mem (input chip_select_primary_n, chip_select_high,
      chip_select_second_n, cpu_load_strobe_n, cache_load_strobe_n,
      burst_step_n, global_store_n, byte_store_enable_n, lane_store_n,
      burst_order_select, out_enable_n, addr, dq,
      output dq_mem_out, dq_mem_oe);
   modport ctl (output chip_select_primary_n, chip_select_high,
      chip_select_second_n, cpu_load_strobe_n, cache_load_strobe_n,
      burst_step_n, global_store_n, byte_store_enable_n, lane_store_n,
      burst_order_select, out_enable_n, addr, dq_ctl_out, dq_ctl_oe,
      input dq);
endinterface

// [sbs_mem.sv]
// Synchronous burst SRAM end: cycle decode, burst counter, storage.
`timescale 1ns/1ns
`include "sbs_regs.svh"
module sbs_mem
   import sbs_pkg::*;
#(
   parameter int ADDR_W = `SBS_ADDR_W,
   parameter int LANES  = `SBS_LANES,
   parameter int LANE_W = `SBS_LANE_W
) (
   input  wire logic  clock,
   input  wire logic  nrst,
   sbs_if.mem         bus,
   output logic [2:0] cycle_kind
);
   localparam int CW = `SBS_CNT_W;
   localparam int DW = LANES * LANE_W;

   // -------------------------------------------------------------
   // Cycle decode
   // -------------------------------------------------------------
   logic        en_true;
   logic        wr_q_in;
   sbs_cyc_e    kind;
   logic [LANES-1:0] lane_we;
   logic        sel_n_q;
   // Combined enable from the two secondary selects.
   assign en_true = bus.chip_select_high & ~bus.chip_select_second_n;
   // Global store writes all lanes; byte store writes chosen lanes.
   always_comb begin
      lane_we = '0;
      if (!bus.global_store_n) begin
         lane_we = '1;
      end else if (!bus.byte_store_enable_n) begin
         lane_we = ~bus.lane_store_n;
      end
   end
   assign wr_q_in = |lane_we;

   // Priority follows the table: deselect, cpu strobe, cache strobe.
   always_comb begin
      if (bus.chip_select_primary_n && !bus.cache_load_strobe_n) begin
         kind = SBS_DESEL;
      end else if (!bus.chip_select_primary_n &&
                   !bus.cpu_load_strobe_n) begin
         kind = en_true ? SBS_BEGIN : SBS_DESEL;
      end else if (!bus.chip_select_primary_n &&
                   !bus.cache_load_strobe_n) begin
         kind = en_true ? SBS_BEGIN : SBS_DESEL;
      end else if (!bus.burst_step_n) begin
         kind = SBS_NEXT;
      end else begin
         kind = SBS_HOLD;
      end
   end
   // A cpu strobe begin is always a read whatever the store pins show.
   logic is_write;
   assign is_write = (kind != SBS_DESEL) &&
      !(kind == SBS_BEGIN && !bus.cpu_load_strobe_n) && wr_q_in;

   // -------------------------------------------------------------
   // Address and burst counter
   // -------------------------------------------------------------
   logic [ADDR_W-1:0] base_q;
   logic [CW-1:0]     start_q;
   logic [CW-1:0]     step_q;
   logic [ADDR_W-1:0] cur_addr;
   logic [CW-1:0]     low_bits;
   logic              order_q;
   logic [CW-1:0]     use_step;
   // A continue cycle moves on before it uses the step; a suspend stays
   // on the step last used, so a continue never repeats the address before it.
   assign use_step = (kind == SBS_NEXT) ? CW'(step_q + 1'b1)
                                        : step_q;
   // Low bits come from the step count, in the chosen order.
   assign low_bits = order_q ? (start_q ^ use_step)
                             : CW'(start_q + use_step);
   assign cur_addr = (kind == SBS_BEGIN) ? bus.addr
                     : {base_q[ADDR_W-1:CW], low_bits};
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         base_q  <= '0;
         start_q <= '0;
         step_q  <= '0;
         order_q <= 1'b0;
      end else begin
         case (kind)
            SBS_BEGIN: begin
               base_q  <= bus.addr;
               start_q <= bus.addr[CW-1:0];
               step_q  <= '0;
               order_q <= bus.burst_order_select;
            end
            // Dummy reads advance exactly like real reads.
            SBS_NEXT: step_q <= CW'(step_q + 1'b1);
            default: ;
         endcase
      end
   end

   // -------------------------------------------------------------
   // Storage and read pipeline
   // -------------------------------------------------------------
   logic [DW-1:0] rd_q;
   logic          rd_act_q;
   logic [DW-1:0] rd2_q;
   logic          rd2_act_q;
   wire  [DW-1:0] rd_word;
   // Per-lane writes; each lane owns its array so that no two processes
   // write one variable, and unselected lanes keep old contents.
   genvar gl;
   generate
      for (gl = 0; gl < LANES; gl++) begin : g_lane
         logic [LANE_W-1:0] lane_mem [0:(1<<ADDR_W)-1];
         always_ff @(posedge clock) begin
            if (is_write && lane_we[gl]) begin
               lane_mem[cur_addr] <= bus.dq[gl*LANE_W +: LANE_W];
            end
         end
         assign rd_word[gl*LANE_W +: LANE_W] = lane_mem[cur_addr];
      end
   endgenerate
   // Two-stage pipeline so read data appears one edge after capture.
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rd_q      <= '0;
         rd_act_q  <= 1'b0;
         rd2_q     <= '0;
         rd2_act_q <= 1'b0;
      end else begin
         rd_act_q  <= (kind != SBS_DESEL) && !is_write;
         rd_q      <= rd_word;
         rd2_act_q <= rd_act_q;
         rd2_q     <= rd_q;
      end
   end
   // Output enable is asynchronous and can only mask drivers.
   assign bus.dq_mem_oe  = rd2_act_q & ~bus.out_enable_n;
   assign bus.dq_mem_out = rd2_q;
   assign cycle_kind     = kind;
endmodule // sbs_mem

// [sbs_ctl.sv]
// Controller end: drives bursts on the SRAM pins.
`timescale 1ns/1ns
`include "sbs_regs.svh"
module sbs_ctl
   import sbs_pkg::*;
#(
   parameter int ADDR_W = `SBS_ADDR_W,
   parameter int DW     = `SBS_LANES*`SBS_LANE_W
) (
   input  wire logic              clock,
   input  wire logic              nrst,
   sbs_if.ctl                     bus,
   input  wire logic              req,
   input  wire logic              req_write,
   input  wire logic              req_burst,
   input  wire logic              req_order,
   input  wire logic [ADDR_W-1:0] req_addr,
   input  wire logic [DW-1:0]     req_wdata,
   output logic                   busy,
   output logic                   rd_valid,
   output logic [DW-1:0]          rd_data
);
   // -------------------------------------------------------------
   // Sequencer
   // -------------------------------------------------------------
   logic [2:0] beats_q;
   logic       wr_q;
   logic       first_q;
   logic [1:0] rv_q;
   logic       wgap_q;
   // Cache strobe loads the first address, then step low bursts.
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         beats_q <= 3'h0;
         wr_q    <= 1'b0;
         first_q <= 1'b0;
         wgap_q  <= 1'b0;
      end else if (beats_q == 3'h0 && req) begin
         beats_q <= req_burst ? 3'h4 : 3'h1;
         wr_q    <= req_write;
         first_q <= 1'b1;
         wgap_q  <= req_write;
      end else if (wgap_q) begin
         wgap_q  <= 1'b0;
      end else if (beats_q != 3'h0) begin
         beats_q <= beats_q - 3'h1;
         first_q <= 1'b0;
      end
   end
   logic act;
   assign act  = (beats_q != 3'h0) && !wgap_q;
   assign busy = beats_q != 3'h0;
   // Idle is a deselect; cpu strobe stays high throughout.
   assign bus.chip_select_primary_n = ~act;
   assign bus.chip_select_high      = 1'b1;
   assign bus.chip_select_second_n  = 1'b0;
   assign bus.cpu_load_strobe_n     = 1'b1;
   assign bus.cache_load_strobe_n   = ~(first_q && act) & act;
   assign bus.burst_step_n          = 1'b0;
   assign bus.global_store_n        = ~(act && wr_q);
   assign bus.byte_store_enable_n   = 1'b1;
   assign bus.lane_store_n          = '1;
   assign bus.burst_order_select    = req_order;
   // Drivers held off through a write pending gap.
   assign bus.out_enable_n          = wr_q;
   assign bus.addr                  = req_addr;
   assign bus.dq_ctl_out            = req_wdata;
   assign bus.dq_ctl_oe             = act && wr_q;

   // Read data returns three edges after issue.
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rv_q     <= 2'h0;
         rd_valid <= 1'b0;
         rd_data  <= '0;
      end else begin
         rv_q     <= {rv_q[0], act && !wr_q};
         rd_valid <= rv_q[1];
         rd_data  <= bus.dq;
      end
   end
endmodule // sbs_ctl

// [sbs_chk_sva.sv]
// Concurrent checks on the pins between the controller and the memory.
`timescale 1ns/1ns
`include "sbs_regs.svh"
module sbs_chk (
   input wire logic                  clock,
   input wire logic                  nrst,
   input wire logic                  chip_select_primary_n,
   input wire logic                  chip_select_high,
   input wire logic                  chip_select_second_n,
   input wire logic                  cpu_load_strobe_n,
   input wire logic                  cache_load_strobe_n,
   input wire logic                  global_store_n,
   input wire logic                  byte_store_enable_n,
   input wire logic [`SBS_LANES-1:0] lane_store_n,
   input wire logic                  out_enable_n,
   input wire logic                  dq_mem_oe,
   input wire logic                  dq_ctl_oe
);
   // ----------------------------------------------------------------
   // Cycle decode as the memory must see it
   // ----------------------------------------------------------------
   // Enable and qualified write are rebuilt here, not taken from the design.
   wire sel = !chip_select_primary_n;
   wire e_ok = chip_select_high && !chip_select_second_n;
   wire w_ok = !global_store_n || (!byte_store_enable_n && !(&lane_store_n));
   wire cpu = !cpu_load_strobe_n;
   wire cch = !cache_load_strobe_n;
   wire rd_bgn = sel && e_ok && (cpu || (cch && !w_ok));
   wire wr_bgn = sel && e_ok && !cpu && cch && w_ok;
   wire ds_pri = !sel && cch;
   wire ds_ena = sel && !e_ok && (cpu || cch);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   sequence seq_rd;
      rd_bgn;
   endsequence
   sequence seq_wr;
      wr_bgn;
   endsequence
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   a_desel_quiet: assert property (ds_pri |-> ##2 !dq_mem_oe)
      else $error("deselect still drove data");
   a_enable_false: assert property (ds_ena |-> ##2 !dq_mem_oe)
      else $error("false enable still drove data");
   a_read_drives: assert property (seq_rd ##2 !out_enable_n |-> dq_mem_oe)
      else $error("read begin gave no data drive");
   a_write_hiz: assert property (seq_wr |-> ##2 !dq_mem_oe)
      else $error("write cycle drove data lines");
   a_oe_gates: assert property (out_enable_n |-> !dq_mem_oe)
      else $error("drive while output enable high");
   a_drive_cause: assert property (dq_mem_oe |->
      $past(rd_bgn || (!w_ok && !cpu && !cch), 2))
      else $error("drive without a read two edges before");
   a_no_contend: assert property (!(dq_mem_oe && dq_ctl_oe))
      else $error("both ends drive data");
   a_ctl_gap: assert property ($rose(dq_ctl_oe) |-> $past(!dq_mem_oe))
      else $error("write drive right after read drive");
endmodule // sbs_chk

// [tb_top.sv]
// Self-checking bench for the controller and memory pair.
`timescale 1ns/1ns
module tb_top;
   logic        clock, nrst, req, req_write, req_burst, req_order, busy;
   logic        rd_valid;
   logic [2:0]  kind_w;
   logic [7:0]  req_addr;
   logic [31:0] req_wdata, rd_data;
   logic [31:0] rdq[$];
   int          error_cnt = 0;
   int          compares = 0;
   sbs_if sbs_if_i ();
   sbs_mem sbs_mem_i (.clock(clock), .nrst(nrst), .bus(sbs_if_i),
      .cycle_kind(kind_w));
   sbs_ctl sbs_ctl_i (.clock(clock), .nrst(nrst), .bus(sbs_if_i), .req(req),
      .req_write(req_write), .req_burst(req_burst), .req_order(req_order),
      .req_addr(req_addr), .req_wdata(req_wdata), .busy(busy),
      .rd_valid(rd_valid), .rd_data(rd_data));
   sbs_chk sbs_chk_i (.clock(clock), .nrst(nrst),
      .chip_select_primary_n(sbs_if_i.chip_select_primary_n),
      .chip_select_high(sbs_if_i.chip_select_high),
      .chip_select_second_n(sbs_if_i.chip_select_second_n),
      .cpu_load_strobe_n(sbs_if_i.cpu_load_strobe_n),
      .cache_load_strobe_n(sbs_if_i.cache_load_strobe_n),
      .global_store_n(sbs_if_i.global_store_n),
      .byte_store_enable_n(sbs_if_i.byte_store_enable_n),
      .lane_store_n(sbs_if_i.lane_store_n),
      .out_enable_n(sbs_if_i.out_enable_n),
      .dq_mem_oe(sbs_if_i.dq_mem_oe), .dq_ctl_oe(sbs_if_i.dq_ctl_oe));
   // ----------------------------------------------------------------
   // Clock, capture and helpers
   // ----------------------------------------------------------------
   // Clock at 50 ns.
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   // Beats are queued so a lost or extra beat shows up as a misorder.
   always @(posedge clock) if (rd_valid === 1'b1) rdq.push_back(rd_data);
   function automatic logic [31:0] pat(input logic [7:0] a);
      return {24'h5ac3e1, a};
   endfunction
   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task pop_chk(input logic [31:0] exp);
      logic [31:0] got;
      got = 'x;
      if (rdq.size() > 0) got = rdq.pop_front();
      chk(got, exp);
   endtask
   // One request; busy must fall within a bounded wait.
   task do_req(input logic w, b, o, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      req <= 1'b1;
      req_write <= w;
      req_burst <= b;
      req_order <= o;
      req_addr <= a;
      req_wdata <= d;
      @(posedge clock);
      req <= 1'b0;
      for (int i = 0; i < 20; i++) begin
         @(negedge clock);
         if (busy === 1'b0) break;
      end
      chk({31'h0, busy}, 32'h0);
      chk({29'h0, kind_w}, {29'h0, sbs_pkg::SBS_DESEL});
      repeat (5) @(posedge clock);
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task t_single;
      for (int i = 0; i < 4; i++) do_req(1, 0, 0, 8'h10 + 8'(i), pat(8'h10 + 8'(i)));
      for (int i = 0; i < 4; i++) do_req(0, 0, 0, 8'h10 + 8'(i), '0);
      for (int i = 0; i < 4; i++) pop_chk(pat(8'h10 + 8'(i)));
      $display("Test single done");
   endtask
   task t_burst(input logic o);
      do_req(0, 1, o, 8'h11, '0);
      for (int k = 0; k < 4; k++) pop_chk(pat(8'h10 | 8'(o ? 1 ^ k : (1 + k) % 4)));
      $display("Test burst order %0d done", o);
   endtask
   task t_burst_write;
      do_req(1, 1, 0, 8'h22, 32'h1234abcd);
      do_req(0, 1, 1, 8'h23, '0);
      for (int k = 0; k < 4; k++) pop_chk(32'h1234abcd);
      chk(32'(rdq.size()), 32'h0);
      $display("Test burst write done");
   endtask
   task end_of_test;
      $display("Counts: %0d compares, %0d errors", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // Main sequence.
   initial begin
      nrst = 1'b0;
      req = 1'b0;
      req_write = 1'b0;
      req_burst = 1'b0;
      req_order = 1'b0;
      req_addr = '0;
      req_wdata = '0;
      repeat (5) @(posedge clock);
      nrst <= 1'b1;
      t_single();
      t_burst(1'b0);
      t_burst(1'b1);
      t_burst_write();
      end_of_test();
   end
   // Watchdog, far beyond the hundred-odd cycles the tests need.
   initial begin
      #(3000 * 50);
      error_cnt++;
      end_of_test();
   end
endmodule // tb_top
